// ### hdl/eeprom_pkg.sv
// Purpose: Shared constants and types for the two-wire EEPROM slave.
// Assumes: 25 MHz system clock.
// Notes:   Identifier value below is arbitrary.
package eeprom_pkg;

    // ****************************************
    // Bus framing
    // ****************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT      = 4'h9;
    localparam int         DEV_ID_MSB    = 7;
    localparam int         DEV_ID_LSB    = 4;
    localparam int         HW_ADDR_MSB   = 3;
    localparam int         HW_ADDR_LSB   = 1;
    localparam int         RW_BIT        = 0;
    // Arbitrary value; the real type identifier is a build-time choice.
    localparam logic [3:0] TYPE_ID_DEF   = 4'h5;

    // ****************************************
    // Memory layout
    // ****************************************
    localparam int         PAGE_BYTES    = 8;
    localparam int         PAGES_SMALL   = 16;
    localparam int         PAGES_LARGE   = 32;
    localparam int         MEM_DEPTH     = PAGES_LARGE * PAGE_BYTES;
    localparam logic [7:0] ADDR_MASK_SML = 8'h7F;
    localparam logic [7:0] ADDR_MASK_LRG = 8'hFF;
    localparam logic [7:0] ADDR_RST      = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         CLK_HZ        = 25_000_000;
    localparam int         T_WR_MS       = 5;
    localparam int         WR_CYCLES     = T_WR_MS * (CLK_HZ / 1000);
    localparam int         WR_CNT_W      = 17;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_WORD  = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_BUSY  = 3'b101
    } slave_state_t;

endpackage

// ### hdl/line_sync.sv
// Purpose: Two-flop synchroniser for the bus lines.
// Assumes: Inputs are asynchronous to clock.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module line_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,   // System clock.
    input  wire logic             srst,    // Synchronous reset.
    input  wire logic [WIDTH-1:0] async_in, // Raw pin levels.
    output logic      [WIDTH-1:0] sync_out  // Synchronised levels.
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### hdl/cond_detect.sv
// Purpose: Finds clock edges and Start/Stop conditions on the bus.
// Assumes: Inputs already synchronised.
// Notes:   All outputs are one-cycle pulses.
`timescale 1ns/1ns
module cond_detect (
    input  wire logic clock,     // System clock.
    input  wire logic srst,      // Synchronous reset.
    input  wire logic scl_s,     // Synchronised clock line.
    input  wire logic sda_s,     // Synchronised data line.
    output logic      scl_rise,  // Clock line rose.
    output logic      scl_fall,  // Clock line fell.
    output logic      start_p,   // Start condition seen.
    output logic      stop_p     // Stop condition seen.
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // A data change while the clock stays high is a Start or a Stop.
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_p  = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_p   = scl_s & scl_q & ~sda_q & sda_s;
endmodule

// ### hdl/eeprom_slave.sv
// What this block does
// - Data change during clock high is Start/Stop.
// - Start: data falls, clock high; leaves Standby.
// - Ignore the bus until a Start.
// - Stop: data rises, clock high; go Standby.
// - Repeated Start accepts new address byte.
// - Transmitter releases; receiver pulls low for ACK.
// - ACK driver releases after ninth clock.
// - Master NACK on read ends transmission.
// - Standby after idle Stop, write end, reset.
// - Standby on address mismatch or read NACK.
// - Memory is 16 or 32 eight-byte pages.
// - Upper nibble must equal type identifier.
// - Bits three to one match address inputs.
// - Small package matches only all-zero bits.
// - Bit zero: one reads, zero writes.
// - ACK address only on full match.
// - Word address follows; small variant drops bit7.
// - Bytes go MSB first, nine clocks each.
// - Sample on rising, change on falling edge.
// - Deaf during the internal write cycle.
//
// Purpose: Two-wire slave front end of a small serial EEPROM.
// Assumes: Bus clock far slower than the system clock.
// Notes:   Data line is open drain; sda_out is always low.
`timescale 1ns/1ns
module eeprom_slave
    import eeprom_pkg::*;
#(
    parameter int         WR_CNT   = WR_CYCLES,   // Internal write time in cycles.
    parameter logic       LARGE    = 1'b1,        // One selects the 2-Kbit variant.
    parameter logic [3:0] TYPE_ID  = TYPE_ID_DEF  // Device type identifier.
) (
    input  wire logic clock,           // System clock.
    input  wire logic srst,            // Synchronous reset, power-on.
    input  wire logic scl_in,          // Bus clock pin.
    input  wire logic sda_in,          // Bus data pin level.
    output logic      sda_out,         // Bus data drive value.
    output logic      sda_oe,          // High while pulling data low.
    input  wire logic hw_addr_in_high, // Hardware address input, top.
    input  wire logic hw_addr_in_mid,  // Hardware address input, middle.
    input  wire logic hw_addr_in_low,  // Hardware address input, bottom.
    input  wire logic small_package,   // High when address inputs absent.
    output logic      standby,         // High in Standby.
    output logic      write_busy       // High during internal write.
);

    // ****************************************
    // Pin synchronisers and condition detect
    // ****************************************
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic [2:0] hw_s;
    logic       small_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_p;
    logic       stop_p;

    line_sync #(.WIDTH(6)) u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in ({small_package, hw_addr_in_high, hw_addr_in_mid,
                    hw_addr_in_low, scl_in, sda_in}),
        .sync_out ({small_s, hw_s, pins_s[1:0]})
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    cond_detect u_cond (
        .clock    (clock),
        .srst     (srst),
        .scl_s    (scl_s),
        .sda_s    (sda_s),
        .scl_rise (scl_rise),
        .scl_fall (scl_fall),
        .start_p  (start_p),
        .stop_p   (stop_p)
    );

    // ****************************************
    // Address byte decode
    // ****************************************
    function automatic logic addr_match(input logic [7:0] b, input logic [2:0] hw,
                                        input logic sml);
        logic [2:0] want;
        want = sml ? 3'h0 : hw;
        return (b[DEV_ID_MSB:DEV_ID_LSB] == TYPE_ID) &&
               (b[HW_ADDR_MSB:HW_ADDR_LSB] == want);
    endfunction

    function automatic logic [7:0] mask_addr(input logic [7:0] a);
        return a & (LARGE ? ADDR_MASK_LRG : ADDR_MASK_SML);
    endfunction

    // ****************************************
    // State
    // ****************************************
    slave_state_t          state_q;
    logic [3:0]            bitcnt_q;
    logic [7:0]            rx_q;
    logic [7:0]            tx_q;
    logic                  rw_q;
    logic                  nack_q;
    logic [7:0]            addr_q;
    logic [7:0]            pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pval_q;
    logic [WR_CNT_W-1:0]   wr_cnt_q;
    logic [7:0]            mem [MEM_DEPTH];
    logic                  active;
    logic                  ev_byte;
    logic                  ev_end;
    logic                  match;
    logic                  pend;
    logic                  load_rd;
    logic                  commit;

    assign active  = (state_q != ST_IDLE) && (state_q != ST_BUSY);
    assign ev_byte = active && scl_fall && (bitcnt_q == BITS_PER_BYTE);
    assign ev_end  = active && scl_fall && (bitcnt_q == ACK_SLOT);
    assign match   = addr_match(rx_q, hw_s, small_s);
    assign pend    = |pval_q;
    assign commit  = stop_p && pend && (state_q == ST_WDATA);
    assign load_rd = ev_end && (((state_q == ST_DEV) && rw_q) ||
                                ((state_q == ST_RDATA) && !nack_q));

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else if (state_q == ST_BUSY) begin
            if (wr_cnt_q == '0) begin
                state_q <= ST_IDLE;
            end
        end else if (start_p) begin
            state_q <= ST_DEV;
        end else if (stop_p) begin
            state_q <= commit ? ST_BUSY : ST_IDLE;
        end else if (ev_byte && (state_q == ST_DEV) && !match) begin
            state_q <= ST_IDLE;
        end else if (ev_end) begin
            case (state_q)
                ST_DEV:   state_q <= rw_q ? ST_RDATA : ST_WORD;
                ST_WORD:  state_q <= ST_WDATA;
                ST_RDATA: state_q <= nack_q ? ST_IDLE : ST_RDATA;
                default:  state_q <= state_q;
            endcase
        end
    end

    // Counts rising clock edges within a byte, ninth being the ACK slot.
    always_ff @(posedge clock) begin
        if (srst || start_p || ev_end) begin
            bitcnt_q <= 4'h0;
        end else if (active && scl_rise && (bitcnt_q != ACK_SLOT)) begin
            bitcnt_q <= bitcnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_q <= 8'h00;
        end else if (active && scl_rise && (bitcnt_q < BITS_PER_BYTE)) begin
            rx_q <= {rx_q[6:0], sda_s};
        end
    end

    always_ff @(posedge clock) begin
        if (srst || start_p) begin
            rw_q <= 1'b0;
        end else if (ev_byte && (state_q == ST_DEV)) begin
            rw_q <= rx_q[RW_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || start_p) begin
            nack_q <= 1'b0;
        end else if ((state_q == ST_RDATA) && scl_rise && (bitcnt_q == BITS_PER_BYTE)) begin
            nack_q <= sda_s;
        end
    end

    // ****************************************
    // Transmit path and data line drive
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_q <= 8'h00;
        end else if (load_rd) begin
            tx_q <= mem[addr_q];
        end else if ((state_q == ST_RDATA) && scl_fall && (bitcnt_q != 4'h0)
                     && (bitcnt_q < BITS_PER_BYTE)) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (srst || start_p || stop_p || !active) begin
            sda_oe <= 1'b0;
        end else if (ev_byte) begin
            case (state_q)
                ST_DEV:   sda_oe <= match;
                ST_WORD:  sda_oe <= 1'b1;
                ST_WDATA: sda_oe <= 1'b1;
                default:  sda_oe <= 1'b0;
            endcase
        end else if (ev_end) begin
            sda_oe <= load_rd ? ~mem[addr_q][7] : 1'b0;
        end else if ((state_q == ST_RDATA) && scl_fall && (bitcnt_q != 4'h0)
                     && (bitcnt_q < BITS_PER_BYTE)) begin
            sda_oe <= ~tx_q[6];
        end
    end

    assign sda_out = 1'b0;

    // ****************************************
    // Address counter and page buffer
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            addr_q <= ADDR_RST;
        end else if (ev_byte && (state_q == ST_WORD)) begin
            addr_q <= mask_addr(rx_q);
        end else if (ev_byte && (state_q == ST_WDATA)) begin
            addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
        end else if (load_rd) begin
            addr_q <= mask_addr(addr_q + 8'h01);
        end
    end

    always_ff @(posedge clock) begin
        if (srst || start_p || commit) begin
            pval_q <= '0;
        end else if (ev_byte && (state_q == ST_WDATA)) begin
            pval_q[addr_q[2:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (ev_byte && (state_q == ST_WDATA)) begin
            pbuf_q[addr_q[2:0]] <= rx_q;
        end
    end

    // Commits every filled page slot at the Stop that starts the write.
    always_ff @(posedge clock) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (commit && pval_q[i]) begin
                mem[{addr_q[7:3], 3'(i)}] <= pbuf_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_cnt_q <= '0;
        end else if (commit) begin
            wr_cnt_q <= WR_CNT_W'(WR_CNT - 1);
        end else if ((state_q == ST_BUSY) && (wr_cnt_q != '0)) begin
            wr_cnt_q <= wr_cnt_q - 1'b1;
        end
    end

    assign standby    = (state_q == ST_IDLE);
    assign write_busy = (state_q == ST_BUSY);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_idle_quiet: assert property ((state_q == ST_IDLE) && !$past(ev_end) |-> !sda_oe)
        else $error("Data line driven in Standby.");
    a_start_exit: assert property (start_p && (state_q != ST_BUSY) |=> state_q == ST_DEV)
        else $error("Start did not leave Standby.");
    a_stop_standby: assert property (stop_p && active && !pend |=> standby && !sda_oe)
        else $error("Stop did not return to Standby.");
    a_nack_mismatch: assert property (ev_byte && (state_q == ST_DEV) && !match
                                      |=> standby ##1 !sda_oe)
        else $error("Mismatched address not refused.");
    a_ack_match: assert property (ev_byte && (state_q == ST_DEV) && match && !start_p
                                  |=> sda_oe)
        else $error("Matching address not acknowledged.");
    a_ack_release: assert property (ev_end && (state_q != ST_DEV || !rw_q)
                                    && state_q != ST_RDATA |=> !sda_oe)
        else $error("ACK not released after ninth clock.");
    a_busy_deaf: assert property (write_busy |=> !sda_oe [*2])
        else $error("Data line driven during write cycle.");
    a_word_load: assert property (ev_byte && (state_q == ST_WORD) && !stop_p && !start_p
                                  |=> addr_q == mask_addr($past(rx_q)))
        else $error("Word address not loaded.");
    a_read_nack: assert property (ev_end && (state_q == ST_RDATA) && nack_q && !start_p
                                  && !stop_p |=> standby && !sda_oe)
        else $error("Read NACK did not end transfer.");

    c_write_cycle: cover property (commit ##1 write_busy);
    c_read_byte: cover property (ev_end && (state_q == ST_RDATA) && !nack_q);
    c_mismatch: cover property (ev_byte && (state_q == ST_DEV) && !match);
    c_rep_start: cover property (start_p && (state_q == ST_WDATA));

endmodule

// ### verification/bus_master_model.sv
// Purpose: Behavioural two-wire bus master that drives the EEPROM slave.
// Assumes: One bus clock lasts 8 system clocks; the data wire has a pull-up.
// Notes:   The testbench calls these tasks through the instance.
`timescale 1ns/1ns
module bus_master_model (
    input  wire logic clock, // System clock.
    input  wire logic sda,   // Resolved data wire.
    output logic      scl,   // Bus clock drive.
    output logic      sda_m  // Data drive; one releases the wire.
);
    // ****************************************
    // Bus primitives
    // ****************************************
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Drops the clock while data stays high, so no Start or Stop is made.
    task automatic clock_low();
        tick(2);
        scl <= 1'b0;
    endtask

    // Works from idle and as a repeated Start after a low clock phase.
    task automatic start_cond();
        tick(4);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask

    // Data moves only while the clock is low; the wire is sampled twice when high.
    task automatic clock_bit(input logic b, output logic s_mid, output logic s_end);
        tick(2);
        sda_m <= b;
        tick(2);
        scl <= 1'b1;
        tick(1);
        #1 s_mid = sda;
        tick(2);
        #1 s_end = sda;
        tick(1);
        scl <= 1'b0;
    endtask

    // Acknowledge is true only if the wire is low at both samples of the ninth high phase.
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s1;
        logic s2;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s1, s2);
        end
        clock_bit(1'b1, s1, s2);
        ack = (s1 === 1'b0) && (s2 === 1'b0);
    endtask

    // The master answers with ack_bit; slot returns the wire level in that clock.
    task automatic read_byte(input logic ack_bit, output logic [7:0] b, output logic slot);
        logic s2;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i], s2);
        end
        clock_bit(ack_bit, slot, s2);
    endtask

    // Dummy clocks until the slave lets the wire go high, nine at most.
    task automatic recover(output int n);
        logic s1;
        logic s2;
        n = 0;
        do begin
            clock_bit(1'b1, s1, s2);
            n++;
        end while (s1 !== 1'b1 && n < 9);
    endtask
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench for the two-wire EEPROM slave.
// Assumes: 25 MHz clock; bus master model in its own file.
// Notes:   Internal write time is shortened through WR_CNT.
`timescale 1ns/1ns
module testbench;
    // ****************************************
    // Setup
    // ****************************************
    localparam int         WR_N = 200;
    localparam logic [3:0] TID  = 4'h6; // Arbitrary identifier.

    logic       clock;
    logic       srst;
    logic       scl;
    logic       sda_m;
    logic       sda_bus;
    logic       sda_out;
    logic       sda_oe;
    logic [2:0] hw_pins;
    logic       small_pkg;
    logic       standby;
    logic       write_busy;
    int         n_mismatch;
    int         checked;

    assign sda_bus = (sda_oe === 1'b1) ? (sda_out & sda_m) : sda_m;

    bus_master_model m (.clock(clock), .sda(sda_bus), .scl(scl), .sda_m(sda_m));

    eeprom_slave #(.WR_CNT(WR_N), .LARGE(1'b1), .TYPE_ID(TID)) dut (
        .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .hw_addr_in_high(hw_pins[2]),
        .hw_addr_in_mid(hw_pins[1]), .hw_addr_in_low(hw_pins[0]),
        .small_package(small_pkg), .standby(standby), .write_busy(write_busy));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] dev(input logic [2:0] hw, input logic rw);
        return {TID, hw, rw};
    endfunction

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check("standby", standby, 1);
        check("busy", write_busy, 0);
        check("oe", sda_oe, 0);
        check("sda_out", sda_out, 0);
    endtask

    task automatic t_no_start();
        logic ack;
        m.clock_low();
        m.write_byte(dev(3'b101, 1'b0), ack);
        check("ack", ack, 0);
        m.tick(4);
        #1 check("standby", standby, 1);
    endtask

    task automatic t_write();
        logic ack;
        int   cnt;
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b0), ack);
        check("ack", ack, 1);
        #1 check("standby", standby, 0);
        m.write_byte(8'h5D, ack);
        check("ack", ack, 1);
        m.write_byte(8'hA5, ack);
        check("ack", ack, 1);
        m.tick(4);
        #1 check("oe", sda_oe, 0);
        m.write_byte(8'h3C, ack);
        check("ack", ack, 1);
        fork
            begin
                m.stop_cond();
                m.start_cond();
                m.write_byte(dev(3'b101, 1'b0), ack);
                check("ack", ack, 0);
                m.stop_cond();
            end
            begin
                cnt = 0;
                while (write_busy !== 1'b1 && cnt < 20) begin
                    @(posedge clock);
                    #1 cnt++;
                end
                cnt = 0;
                while (write_busy === 1'b1 && cnt < 1000) begin
                    @(posedge clock);
                    #1 cnt++;
                end
                check("busy", cnt, WR_N);
            end
        join
        check("standby", standby, 1);
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b0), ack);
        check("ack", ack, 1);
        m.stop_cond();
        m.tick(2);
        #1 check("standby", standby, 1);
    endtask

    task automatic t_read();
        logic       ack;
        logic       slot;
        logic [7:0] d;
        int         n;
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b0), ack);
        m.write_byte(8'h5D, ack);
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b1), ack);
        check("ack", ack, 1);
        m.read_byte(1'b0, d, slot);
        check("data", d, 8'hA5);
        check("slot", slot, 0);
        m.recover(n);
        check("recovery", n, 3);
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b0), ack);
        m.write_byte(8'h5E, ack);
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b1), ack);
        m.read_byte(1'b1, d, slot);
        check("data", d, 8'h3C);
        check("slot", slot, 1);
        m.tick(6);
        #1 check("oe", sda_oe, 0);
        check("standby", standby, 1);
        m.stop_cond();
    endtask

    task automatic t_mismatch();
        logic       ack;
        logic [7:0] bad [2] = '{{~TID, 3'b101, 1'b0}, {TID, 3'b100, 1'b0}};
        foreach (bad[i]) begin
            m.start_cond();
            m.write_byte(bad[i], ack);
            check("ack", ack, 0);
            #1 check("standby", standby, 1);
            m.stop_cond();
        end
    endtask

    task automatic t_small();
        logic ack;
        @(posedge clock) small_pkg <= 1'b1;
        m.tick(4);
        m.start_cond();
        m.write_byte(dev(3'b000, 1'b0), ack);
        check("ack", ack, 1);
        m.stop_cond();
        m.start_cond();
        m.write_byte(dev(3'b101, 1'b0), ack);
        check("ack", ack, 0);
        m.stop_cond();
        small_pkg <= 1'b0;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        srst       = 1'b1;
        hw_pins    = 3'b101;
        small_pkg  = 1'b0;
        n_mismatch = 0;
        checked    = 0;
        t_reset();
        t_no_start();
        t_write();
        t_read();
        t_mismatch();
        t_small();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
